// *** verilog/ecf_rx_filter.sv ***
// Receive digest filter with its commit-and-rewind packet FIFO.
`timescale 1ns/1ns

// Packet FIFO: words become visible to the reader only once committed, so
// a packet that fails its digest check can be rewound away before any
// word of it has left the block.
module ecf_fifo
  import ecf_pkg::*;
#(
  parameter int WIDTH = DATA_W + SIDE_W,
  parameter int DEPTH = FIFO_DEPTH,
  parameter int AW    = FIFO_AW
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             reset_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             commit,
  input  wire logic             rewind,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      wr_d;
  logic [AW:0]      cmt_q;
  logic [AW:0]      cmt_d;
  logic [AW:0]      rd_q;
  logic [AW:0]      rd_d;
  logic [AW:0]      fill;
  logic             do_wr;

  always_comb begin
    fill      = wr_q - rd_q;
    in_ready  = (fill != (AW + 1)'(DEPTH));
    out_valid = (cmt_q != rd_q);
    out_data  = mem_q[rd_q[AW-1:0]];
    // A rewind wins over a write in the same cycle: the word it would
    // have stored belongs to the packet that is being thrown away.
    do_wr     = in_valid && in_ready && !rewind;
    wr_d      = rewind ? cmt_q : wr_q + (AW + 1)'(do_wr);
    cmt_d     = commit ? wr_d : cmt_q;
    rd_d      = rd_q + (AW + 1)'(out_valid && out_ready);
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      wr_q  <= '0;
      cmt_q <= '0;
      rd_q  <= '0;
    end else begin
      wr_q  <= wr_d;
      cmt_q <= cmt_d;
      rd_q  <= rd_d;
    end
  end

  // Storage carries no reset; only committed words are ever read.
  always_ff @(posedge clock) begin
    if (do_wr) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end

endmodule

// Overview of operation
// - With checking on, a packet whose digest fails raises a one-cycle error.
// - With checking off, no digest error is ever raised.
// - With checking on, a bad-digest packet is discarded, never delivered.
// - With forwarding off, a carried digest is stripped from the packet.
// - With forwarding on, a carried digest is delivered intact.
// - Packets without a digest pass unchanged and without error.
// - A packet carries a digest exactly when its header digest bit is one.
// - Checking enable comes from the error capabilities control field.
module ecf_rx_filter
  import ecf_pkg::*;
(
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              reset_n,
  // Configuration from the error capabilities and control register
  input  wire logic              ecrc_check_en,
  input  wire logic              ecrc_fwd_en,
  // Packets from the transaction layer
  input  wire logic              rx_valid,
  output logic                   rx_ready,
  input  wire logic [DATA_W-1:0] rx_data,
  input  wire logic              rx_sop,
  input  wire logic              rx_eop,
  // Packets to the application
  output logic                   app_valid,
  input  wire logic              app_ready,
  output logic      [DATA_W-1:0] app_data,
  output logic                   app_sop,
  output logic                   app_eop,
  // Status
  output logic                   ecrc_err
);

  ecf_hold_t         st_q;
  ecf_hold_t         st_d;
  logic [DATA_W-1:0] hold_q;
  logic [DATA_W-1:0] hold_d;
  logic              hsop_q;
  logic              hsop_d;
  logic              td_q;
  logic              td_d;
  logic              chk_q;
  logic              chk_d;
  logic              fwd_q;
  logic              fwd_d;
  logic [31:0]       crc_q;
  logic [31:0]       crc_d;
  logic              err_q;
  logic              err_d;

  logic              acc;
  logic              pkt_td;
  logic              pkt_chk;
  logic              pkt_fwd;
  logic              is_dig;
  logic              drop;
  logic [31:0]       crc_in;
  logic [31:0]       word_v;
  logic              wr_v;
  logic              wr_eop;
  logic              commit;
  logic              rewind;
  logic              fifo_in_ready;
  logic [DATA_W+SIDE_W-1:0] fifo_out;

  // Bytes enter most significant first, each byte least significant bit
  // first, matching the order the bytes travel on the link.
  function automatic logic [31:0] ecf_crc_word(input logic [31:0] crc,
                                               input logic [31:0] data);
    logic [31:0] c;
    logic        fb;
    c  = crc;
    fb = 1'b0;
    for (int i = 0; i < 4; i++) begin
      for (int b = 0; b < 8; b++) begin
        fb = c[31] ^ data[24 - 8 * i + b];
        c  = {c[30:0], 1'b0} ^ (fb ? CRC_POLY : 32'h00000000);
      end
    end
    return c;
  endfunction

  // Final digest value: the complemented remainder, bit reversed.
  function automatic logic [31:0] ecf_crc_final(input logic [31:0] crc);
    logic [31:0] r;
    r = 32'h00000000;
    for (int i = 0; i < 32; i++) begin
      r[i] = ~crc[31 - i];
    end
    return r;
  endfunction

  always_comb begin
    // The held stage takes a word only when the word it holds can move
    // into the FIFO. The last stage takes nothing while it flushes, which
    // costs one idle cycle after every packet that ends in a kept word.
    rx_ready = (st_q != ECF_LAST) && ((st_q == ECF_EMPTY) || fifo_in_ready);
    acc      = rx_valid && rx_ready;
    // Settings are frozen at the first word so a change mid-packet
    // cannot split one packet between two treatments.
    pkt_td   = rx_sop ? (rx_data[TD_BIT] == TD_SET) : td_q;
    pkt_chk  = rx_sop ? ecrc_check_en : chk_q;
    pkt_fwd  = rx_sop ? ecrc_fwd_en : fwd_q;
    is_dig   = rx_eop && pkt_td && (st_q == ECF_MID);
    // The remainder restarts at every first word, so a dropped packet
    // leaves nothing behind that could spoil the next one.
    crc_in   = rx_sop ? CRC_SEED : crc_q;
    word_v   = rx_data;
    if (rx_sop) begin
      // Variant header bits count as ones in the digest.
      word_v[TYPE0_BIT] = 1'b1;
      word_v[EP_BIT]    = 1'b1;
    end
    drop     = is_dig && pkt_chk
               && (ecf_crc_final(crc_in) != rx_data);

    st_d   = st_q;
    hold_d = hold_q;
    hsop_d = hsop_q;
    td_d   = td_q;
    chk_d  = chk_q;
    fwd_d  = fwd_q;
    crc_d  = crc_q;
    err_d  = 1'b0;
    wr_v   = 1'b0;
    wr_eop = 1'b0;
    commit = 1'b0;
    rewind = 1'b0;

    unique case (st_q)
      ECF_EMPTY: begin
        if (acc) begin
          hold_d = rx_data;
          hsop_d = rx_sop;
          td_d   = pkt_td;
          chk_d  = pkt_chk;
          fwd_d  = pkt_fwd;
          crc_d  = ecf_crc_word(crc_in, word_v);
          st_d   = rx_eop ? ECF_LAST : ECF_MID;
        end
      end
      ECF_MID: begin
        if (acc) begin
          wr_v = 1'b1;
          if (drop) begin
            // Nothing of this packet was committed, so it vanishes.
            wr_v   = 1'b0;
            rewind = 1'b1;
            err_d  = 1'b1;
            st_d   = ECF_EMPTY;
          end else if (is_dig && !pkt_fwd) begin
            wr_eop = 1'b1;
            commit = 1'b1;
            st_d   = ECF_EMPTY;
          end else begin
            // Digest-free words and kept digests move on alike.
            hold_d = rx_data;
            hsop_d = rx_sop;
            crc_d  = ecf_crc_word(crc_in, word_v);
            st_d   = rx_eop ? ECF_LAST : ECF_MID;
          end
        end
      end
      ECF_LAST: begin
        // The closing word waits here for room; input stays shut until
        // the whole packet is committed.
        wr_v   = 1'b1;
        wr_eop = 1'b1;
        if (fifo_in_ready) begin
          commit = 1'b1;
          st_d   = ECF_EMPTY;
        end
      end
      // The one unused code can only come from an upset; start afresh.
      default: st_d = ECF_EMPTY;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      st_q   <= ECF_EMPTY;
      hold_q <= '0;
      hsop_q <= 1'b0;
      td_q   <= 1'b0;
      chk_q  <= 1'b0;
      fwd_q  <= 1'b0;
      crc_q  <= CRC_SEED;
      err_q  <= 1'b0;
    end else begin
      st_q   <= st_d;
      hold_q <= hold_d;
      hsop_q <= hsop_d;
      td_q   <= td_d;
      chk_q  <= chk_d;
      fwd_q  <= fwd_d;
      crc_q  <= crc_d;
      err_q  <= err_d;
    end
  end

  // A packet longer than the FIFO can never commit and stalls the input;
  // the trade is a small buffer against full store-and-forward.
  ecf_fifo #(
    .WIDTH (DATA_W + SIDE_W),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clock     (clock),
    .reset_n   (reset_n),
    .in_valid  (wr_v),
    .in_ready  (fifo_in_ready),
    .in_data   ({hsop_q, wr_eop, hold_q}),
    .commit    (commit),
    .rewind    (rewind),
    .out_valid (app_valid),
    .out_ready (app_ready),
    .out_data  (fifo_out)
  );

  always_comb begin
    app_sop  = fifo_out[DATA_W+1];
    app_eop  = fifo_out[DATA_W];
    app_data = fifo_out[DATA_W-1:0];
    ecrc_err = err_q;
  end

endmodule

// *** verilog/ecf_pkg.sv ***
// Constants and types shared by the receive digest filter.
package ecf_pkg;

  localparam int DATA_W     = 32;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW    = 4;
  localparam int SIDE_W     = 2;

  // Header bit positions within the first word of a packet.
  localparam int TD_BIT    = 15;
  localparam int TYPE0_BIT = 24;
  localparam int EP_BIT    = 14;

  localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
  localparam logic [31:0] CRC_SEED = 32'hFFFFFFFF;
  localparam logic        TD_SET   = 1'b1;

  // Holding stage of the filter, Gray coded along empty, middle, last.
  typedef enum logic [1:0] {
    ECF_EMPTY = 2'b00,
    ECF_MID   = 2'b01,
    ECF_LAST  = 2'b11
  } ecf_hold_t;

endpackage

// *** sim/ecf_rx_filter_checker.sv ***
// Port assertions for the receive digest filter.
`timescale 1ns/1ns
module ecf_rx_filter_checker
  import ecf_pkg::*;
(
  // Clock and reset
  input wire logic              clock,
  input wire logic              reset_n,
  // Watched ports
  input wire logic              ecrc_check_en,
  input wire logic              rx_valid,
  input wire logic              rx_ready,
  input wire logic [DATA_W-1:0] rx_data,
  input wire logic              rx_sop,
  input wire logic              rx_eop,
  input wire logic              app_valid,
  input wire logic              app_ready,
  input wire logic [DATA_W-1:0] app_data,
  input wire logic              app_sop,
  input wire logic              app_eop,
  input wire logic              ecrc_err
);
  logic td_q;
  logic chk_q;
  logic mid_q;
  // Settings are latched per packet, so the checker keeps its own copy.
  always_ff @(posedge clock) begin
    if (rx_valid && rx_ready && rx_sop) begin
      td_q  <= rx_data[TD_BIT];
      chk_q <= ecrc_check_en;
    end
    if (!reset_n)
      mid_q <= 1'b0;
    else if (app_valid && app_ready)
      mid_q <= !app_eop;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  reset_idle_a: assert property (disable iff (1'b0)
    !reset_n |=> rx_ready && !app_valid && !ecrc_err) else $error("reset");
  err_pulse_a: assert property (
    ecrc_err |=> !ecrc_err) else $error("error pulse too long");
  err_cause_a: assert property (
    ecrc_err |-> $past(rx_valid) && $past(rx_ready) && $past(rx_eop))
    else $error("cause");
  err_check_a: assert property (
    ecrc_err |-> $past(chk_q)) else $error("error with checking off");
  err_digest_a: assert property (
    ecrc_err |-> $past(td_q)) else $error("error without digest");
  app_hold_a: assert property (
    app_valid && !app_ready |=> app_valid && $stable(app_data)
    && $stable(app_eop)) else $error("output word not held");
  app_start_a: assert property (
    app_valid && !mid_q |-> app_sop) else $error("packet start lost");
  flush_gap_a: assert property (
    rx_valid && rx_ready && rx_eop && !rx_sop && !td_q |=> !rx_ready)
    else $error("no gap after plain packet");
endmodule

// *** sim/ecf_app_sink.sv ***
// Application receive model that collects delivered words.
`timescale 1ns/1ns
module ecf_app_sink
  import ecf_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // Delivered stream
  input  wire logic        app_valid,
  output logic             app_ready,
  input  wire logic [31:0] app_data,
  input  wire logic        app_sop,
  input  wire logic        app_eop,
  // Pacing and mode from the bench
  input  wire logic        hold,
  input  wire logic        slow,
  input  wire logic        fwd_en
);
  logic        tick_q;
  logic        td_q;
  logic [31:0] crc_q;
  logic [33:0] got [$];
  int          bad_dig = 0;
  // The application's own digest arithmetic, kept apart from the filter.
  function automatic logic [31:0] step(logic [31:0] c, logic [31:0] d);
    for (int i = 0; i < 32; i++)
      c = {c[30:0], 1'b0}
        ^ ((c[31] ^ d[24 - 8 * (i / 8) + i % 8]) ? CRC_POLY : 32'h00000000);
    return c;
  endfunction
  function automatic logic [31:0] seal(logic [31:0] c);
    logic [31:0] r;
    for (int i = 0; i < 32; i++)
      r[i] = ~c[31 - i];
    return r;
  endfunction
  assign app_ready = !hold && !(slow && tick_q);
  always @(posedge clock) begin
    tick_q <= reset_n && !tick_q;
    if (reset_n && app_valid && app_ready) begin
      got.push_back({app_eop, app_sop, app_data});
      if (app_sop)
        td_q <= app_data[TD_BIT];
      // In forwarding mode a kept digest closes the packet and is checked.
      if (app_eop && !app_sop && td_q && fwd_en) begin
        if (app_data !== seal(crc_q))
          bad_dig++;
      end else begin
        crc_q <= step(app_sop ? CRC_SEED : crc_q,
                      app_sop ? (app_data | 32'h01004000) : app_data);
      end
    end
  end
endmodule

// *** sim/ecf_rx_filter_test.sv ***
// Self-checking bench for the receive digest filter.
`timescale 1ns/1ns
module ecf_rx_filter_test
  import ecf_pkg::*;
;
  logic        clock, reset_n, ecrc_check_en, ecrc_fwd_en, hold, slow;
  logic        rx_valid, rx_ready, rx_sop, rx_eop, app_valid, app_ready;
  logic        app_sop, app_eop, ecrc_err;
  logic [31:0] rx_data, app_data;
  logic [33:0] exp_q [$];
  int          num_errors = 0, comparisons = 0, errs = 0, exp_err = 0;
  int          exp_bad = 0;
  ecf_rx_filter dut_u (
    .clock         (clock),
    .reset_n       (reset_n),
    .ecrc_check_en (ecrc_check_en),
    .ecrc_fwd_en   (ecrc_fwd_en),
    .rx_valid      (rx_valid),
    .rx_ready      (rx_ready),
    .rx_data       (rx_data),
    .rx_sop        (rx_sop),
    .rx_eop        (rx_eop),
    .app_valid     (app_valid),
    .app_ready     (app_ready),
    .app_data      (app_data),
    .app_sop       (app_sop),
    .app_eop       (app_eop),
    .ecrc_err      (ecrc_err)
  );
  ecf_app_sink sink_u (
    .clock     (clock),
    .reset_n   (reset_n),
    .app_valid (app_valid),
    .app_ready (app_ready),
    .app_data  (app_data),
    .app_sop   (app_sop),
    .app_eop   (app_eop),
    .hold      (hold),
    .slow      (slow),
    .fwd_en    (ecrc_fwd_en)
  );
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) if (ecrc_err === 1'b1) errs++;
  task automatic chk_w(string n, logic [33:0] e, logic [33:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk_n(string n, int e, int g);
    comparisons++;
    if (g != e) begin
      num_errors++;
      $display("[ERR] %s exp %0d got %0d", n, e, g);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  function automatic logic [31:0] crc(logic [31:0] c, logic [31:0] d);
    for (int i = 0; i < 32; i++)
      c = {c[30:0], 1'b0}
        ^ ((c[31] ^ d[24 - 8 * (i / 8) + i % 8]) ? CRC_POLY : 32'h00000000);
    return c;
  endfunction
  // Holds the word until taken; valid stays up until drain lowers it.
  task automatic put(logic [31:0] d, logic s, logic e);
    int t;
    rx_valid = 1'b1;
    rx_data = d;
    rx_sop = s;
    rx_eop = e;
    t = 0;
    while (rx_ready !== 1'b1) begin
      if (++t > 300) begin
        chk_n("rx_ready wait", 1, 0);
        summarize();
      end
      @(negedge clock);
    end
    @(negedge clock);
  endtask
  task automatic send(int n, logic td, logic bad);
    logic [31:0] w [8];
    logic [31:0] c;
    int          m, last;
    logic        keep;
    for (int k = 0; k < 8; k++)
      w[k] = 32'h40000000 ^ (32'(k) << 20) ^ 32'(n);
    w[0][TD_BIT] = td;
    c = crc(CRC_SEED, w[0] | 32'h01004000);
    for (int k = 1; k < n; k++)
      c = crc(c, w[k]);
    for (int i = 0; i < 32; i++)
      w[n][i] = ~c[31 - i] ^ (bad && i == 0);
    m = n + td;
    keep = !(td && bad && ecrc_check_en);
    exp_err += int'(!keep);
    exp_bad += int'(keep && td && bad && ecrc_fwd_en);
    last = (td && !ecrc_fwd_en) ? n - 1 : m - 1;
    for (int k = 0; k < m; k++) begin
      put(w[k], k == 0, k == m - 1);
      if (keep && k <= last)
        exp_q.push_back({k == last, k == 0, w[k]});
    end
  endtask
  task automatic drain();
    int t;
    rx_valid = 1'b0;
    t = 0;
    while (sink_u.got.size() < exp_q.size()) begin
      if (++t > 300) begin
        chk_n("drain wait", 1, 0);
        summarize();
      end
      @(negedge clock);
    end
    repeat (8) @(negedge clock);
    chk_n("words", exp_q.size(), sink_u.got.size());
    chk_n("digest errors", exp_err, errs);
    chk_n("kept bad digests", exp_bad, sink_u.bad_dig);
    while (exp_q.size() > 0 && sink_u.got.size() > 0)
      chk_w("word", exp_q.pop_front(), sink_u.got.pop_front());
    exp_q.delete();
    sink_u.got.delete();
  endtask
  task automatic test_table();
    for (int m = 0; m < 12; m++) begin
      ecrc_fwd_en = m / 6 == 1;
      ecrc_check_en = m / 3 % 2 == 1;
      send(3, m % 3 != 0, m % 3 == 2);
      drain();
    end
    $display("test_table done");
  endtask
  task automatic test_pair();
    ecrc_check_en = 1'b1;
    ecrc_fwd_en = 1'b1;
    send(2, 1'b1, 1'b1);
    send(5, 1'b1, 1'b0);
    send(1, 1'b0, 1'b0);
    drain();
    $display("test_pair done");
  endtask
  task automatic test_fill();
    ecrc_fwd_en = 1'b0;
    hold = 1'b1;
    fork
      for (int p = 0; p < 5; p++)
        send(4, p == 2, 1'b0);
      begin
        repeat (60) @(negedge clock);
        chk_w("ready when full", 34'h000000000, {33'h000000000, rx_ready});
        hold = 1'b0;
        slow = 1'b1;
      end
    join
    drain();
    $display("test_fill done");
  endtask
  initial begin
    {reset_n, ecrc_check_en, ecrc_fwd_en, hold, slow} = 5'h00;
    {rx_valid, rx_sop, rx_eop, rx_data} = 35'h000000000;
    repeat (16) @(negedge clock);
    reset_n = 1'b1;
    @(negedge clock);
    test_table();
    test_pair();
    test_fill();
    summarize();
  end
endmodule
bind ecf_rx_filter ecf_rx_filter_checker chk_u (
  .clock         (clock),
  .reset_n       (reset_n),
  .ecrc_check_en (ecrc_check_en),
  .rx_valid      (rx_valid),
  .rx_ready      (rx_ready),
  .rx_data       (rx_data),
  .rx_sop        (rx_sop),
  .rx_eop        (rx_eop),
  .app_valid     (app_valid),
  .app_ready     (app_ready),
  .app_data      (app_data),
  .app_sop       (app_sop),
  .app_eop       (app_eop),
  .ecrc_err      (ecrc_err)
);
